// ==== src/spc_top.sv ====
// spc_top: sync pulse, reference select, phase mode, overvoltage and
// multi-device sync control for two channels
// assumes Avalon-MM master, synchronous pins, 100 MHz mclk
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_top
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // register bus
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // aux sync port
    input  wire logic        aux_in,
    output logic             aux_out,
    output logic             aux_oe,
    // reference clock port
    input  wire logic        reference_clock_port_in,
    output logic             reference_clock_port_out,
    output logic             reference_clock_port_oe,
    // trigger and sync port
    input  wire logic        trig_in,
    output logic             trig_out,
    output logic             trig_oe,
    // first_channel
    input  wire logic [15:0] first_channel_vmag_mv,
    output logic      [31:0] first_channel_phase,
    output logic             first_channel_out_en,
    // second_channel
    input  wire logic [15:0] second_channel_vmag_mv,
    output logic      [31:0] second_channel_phase,
    output logic             second_channel_out_en
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rsync_q;
    logic       rstn;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'b00;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rstn = rsync_q[1];

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    logic      wait_q, wait_d;
    spc_word_t rdata_q, rdata_d, rmux;
    logic      req, wr_go;
    logic      ch_sel;
    logic [4:0] ch_off;
    logic      ch_hit;

    assign req    = avs_read || avs_write;
    assign wr_go  = avs_write && !wait_q;
    assign ch_sel = avs_address[`SPC_A_CH_BIT];
    assign ch_off = avs_address[4:0];
    assign ch_hit = (avs_address[7:6] == 2'b00) && (ch_off >= `SPC_O_CFG)
                    && (ch_off <= `SPC_O_LEVEL) && (ch_off[1:0] == 2'b00);

    function automatic spc_word_t merge(spc_word_t old, spc_word_t wd,
                                        logic [3:0] be);
        spc_word_t m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // waitrequest drops for one cycle after a request shows up
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if (req && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = avs_read ? rmux : `SPC_ZERO;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_q  <= 1'b1;
            rdata_q <= `SPC_ZERO;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // global registers
    // ----------------------------------------
    spc_word_t ctrl_q, ctrl_d, ratio_q, ratio_d, dly_q, dly_d;
    logic      host_send;
    logic      locked, slave;

    assign locked    = ctrl_q[`SPC_C_LOCKED];
    assign slave     = ctrl_q[`SPC_C_SLAVE];
    assign host_send = wr_go && (avs_address == `SPC_A_CMD) && !slave
                       && avs_byteenable[0] && avs_writedata[`SPC_K_SEND];

    always_comb begin
        ctrl_d  = ctrl_q;
        ratio_d = ratio_q;
        dly_d   = dly_q;
        if (wr_go && avs_address == `SPC_A_CTRL) begin
            ctrl_d = merge(ctrl_q, avs_writedata, avs_byteenable);
        end
        if (wr_go && avs_address == `SPC_A_RATIO) begin
            ratio_d = merge(ratio_q, avs_writedata, avs_byteenable);
        end
        if (wr_go && avs_address == `SPC_A_DELAY) begin
            dly_d = merge(dly_q, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q  <= `SPC_CTRL_RST;
            ratio_q <= `SPC_ZERO;
            dly_q   <= `SPC_ZERO;
        end else begin
            ctrl_q  <= ctrl_d;
            ratio_q <= ratio_d;
            dly_q   <= dly_d;
        end
    end

    // ----------------------------------------
    // slave sync event and delay
    // ----------------------------------------
    spc_slv_st_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic        tprev_q, tprev_d;
    logic        slv_rst, freq_wr, acc_rst;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        tprev_d = trig_in;
        slv_rst = 1'b0;
        unique case (st_q)
            SS_IDLE: begin
                if (slave && trig_in && !tprev_q) begin
                    st_d  = SS_WAIT;
                    cnt_d = dly_q[`SPC_F_DELAY];
                end
            end
            SS_WAIT: begin
                if (cnt_q == 16'h0000) begin
                    st_d    = SS_IDLE;
                    slv_rst = 1'b1;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= SS_IDLE;
            cnt_q   <= 16'h0000;
            tprev_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            tprev_q <= tprev_d;
        end
    end

    // both channels always restart together, never one alone
    assign acc_rst = (freq_wr && locked) || slv_rst || host_send;

    // ----------------------------------------
    // per channel logic
    // ----------------------------------------
    spc_word_t ftw[2], cfg[2], rd_ch[2][5];
    logic      trip[2], sync_tr[2], sync_ok[2], fwr[2], ovp[2];
    logic [15:0] vmag[2];

    assign vmag[0] = first_channel_vmag_mv;
    assign vmag[1] = second_channel_vmag_mv;
    assign freq_wr = fwr[0] || fwr[1];

    for (genvar i = 0; i < 2; i++) begin : g_ch
        spc_word_t cfg_q, cfg_d, ftw_q, ftw_d, mftw_q, mftw_d;
        spc_word_t ph_q, ph_d, lvl_q, lvl_d, eff_q, eff_d;
        spc_word_t acc_q, acc_d, macc_q, macc_d, out_q, out_d;
        logic      wrap_q, wrap_d, mwrap_q, mwrap_d, ovp_q, ovp_d;
        logic      hit, imod, ok, big;
        logic [15:0] lim;

        assign hit  = wr_go && ch_hit && (ch_sel == 1'(i));
        assign fwr[i] = hit && (ch_off == `SPC_O_FTW || ch_off == `SPC_O_MFTW);
        assign imod = (cfg_q[`SPC_F_MOD] != `SPC_M_NONE)
                      && (cfg_q[`SPC_F_MOD] <= `SPC_M_LAST) && !cfg_q[`SPC_F_MEXT];
        assign big  = (lvl_q[`SPC_F_AMP] >= `SPC_AMP_BIG_MV)
                      || (lvl_q[`SPC_F_OFS] >= `SPC_OFS_BIG_MV);
        assign lim  = big ? `SPC_OVP_HI_MV : `SPC_OVP_LO_MV;
        assign trip[i] = (vmag[i] > lim);

        // settings; a trip overrides a same-cycle output enable write
        always_comb begin
            cfg_d  = cfg_q;
            ftw_d  = ftw_q;
            mftw_d = mftw_q;
            ph_d   = ph_q;
            lvl_d  = lvl_q;
            if (hit) begin
                unique case (ch_off)
                    `SPC_O_CFG:   cfg_d  = merge(cfg_q, avs_writedata, avs_byteenable);
                    `SPC_O_FTW:   ftw_d  = merge(ftw_q, avs_writedata, avs_byteenable);
                    `SPC_O_MFTW:  mftw_d = merge(mftw_q, avs_writedata, avs_byteenable);
                    `SPC_O_PHASE: begin
                        if (locked) begin
                            ph_d = merge(ph_q, avs_writedata, avs_byteenable);
                        end
                    end
                    `SPC_O_LEVEL: lvl_d  = merge(lvl_q, avs_writedata, avs_byteenable);
                    default: ;
                endcase
            end
            if (trip[i]) begin
                cfg_d[`SPC_F_OUTEN] = 1'b0;
            end
        end

        // ratio follower: the derived word is an exact multiple
        always_comb begin
            eff_d = ftw_q;
            if (ctrl_q[`SPC_C_COMP] && (ratio_q[`SPC_R_DIR] == (i == 0))) begin
                eff_d = 32'(ftw[1-i] * ratio_q[`SPC_F_RATIO]);
            end
        end

        // accumulators; 33-bit sums give the wrap carry
        always_comb begin
            {wrap_d, acc_d}   = {1'b0, acc_q} + {1'b0, eff_q};
            {mwrap_d, macc_d} = {1'b0, macc_q} + {1'b0, mftw_q};
            if (acc_rst) begin
                acc_d   = `SPC_ZERO;
                macc_d  = `SPC_ZERO;
                wrap_d  = 1'b0;
                mwrap_d = 1'b0;
            end
            out_d = acc_q + ph_q;
        end

        // sticky alert, status write-one clears, a new trip wins
        always_comb begin
            ovp_d = ovp_q;
            if (wr_go && avs_address == `SPC_A_STATUS && avs_byteenable[0]
                && avs_writedata[`SPC_S_OVP0 + i]) begin
                ovp_d = 1'b0;
            end
            if (trip[i]) begin
                ovp_d = 1'b1;
            end
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                {cfg_q, ftw_q, mftw_q, ph_q, lvl_q, eff_q, acc_q, macc_q, out_q} <= '0;
                {wrap_q, mwrap_q, ovp_q} <= '0;
            end else begin
                {cfg_q, ftw_q, mftw_q, ph_q, lvl_q, eff_q, acc_q, macc_q, out_q}
                    <= {cfg_d, ftw_d, mftw_d, ph_d, lvl_d, eff_d, acc_d, macc_d, out_d};
                {wrap_q, mwrap_q, ovp_q} <= {wrap_d, mwrap_d, ovp_d};
            end
        end

        // which wrap marks a sync period for this channel
        always_comb begin
            ok = !cfg_q[`SPC_F_SWEEP] && !cfg_q[`SPC_F_BURST]
                 && !cfg_q[`SPC_F_MEXT];
            if (imod) begin
                sync_tr[i] = mwrap_q;
            end else if (cfg_q[`SPC_F_WAVE] == `SPC_W_ARB) begin
                sync_tr[i] = wrap_q;
            end else begin
                sync_tr[i] = wrap_q;
                ok = ok && (cfg_q[`SPC_F_WAVE] == `SPC_W_BASIC)
                     && ({32'h0000_0000, eff_q} <= `SPC_FTW_MAX);
            end
            sync_ok[i] = ok;
        end

        assign ftw[i]      = eff_q;
        assign cfg[i]      = cfg_q;
        assign ovp[i]      = ovp_q;
        assign rd_ch[i]    = '{cfg_q, ftw_q, mftw_q, ph_q, lvl_q};
        if (i == 0) begin : g_o0
            assign first_channel_phase  = out_q;
            assign first_channel_out_en = cfg_q[`SPC_F_OUTEN];
        end else begin : g_o1
            assign second_channel_phase  = out_q;
            assign second_channel_out_en = cfg_q[`SPC_F_OUTEN];
        end
    end

    // ----------------------------------------
    // sync pulse and aux port direction
    // ----------------------------------------
    logic src, sync_go, sync_kill, aoe_q, aoe_d;

    assign src       = ctrl_q[`SPC_C_SRC];
    assign sync_kill = !ctrl_q[`SPC_C_SYNC_EN] || !sync_ok[src];
    assign sync_go   = !sync_kill && sync_tr[src];
    assign aoe_d     = ctrl_q[`SPC_C_SYNC_EN] && !cfg[src][`SPC_F_MEXT];

    spc_pulse u_sync (
        .clk   (mclk),
        .rst_n (rstn),
        .trig  (sync_go),
        .clr   (sync_kill),
        .pulse (aux_out)
    );

    // host sync event uses the same fixed width on the trigger port
    spc_pulse u_trig (
        .clk   (mclk),
        .rst_n (rstn),
        .trig  (host_send),
        .clr   (slave),
        .pulse (trig_out)
    );

    // ----------------------------------------
    // reference select, drive and monitor
    // ----------------------------------------
    logic [2:0] div_q, div_d;
    logic       rclk_q, rclk_d, roe_q, roe_d, toe_q, toe_d, refmiss;

    // divider makes the outgoing 10 MHz reference from mclk
    always_comb begin
        div_d  = div_q + 3'h1;
        rclk_d = rclk_q;
        if (div_q == 3'(`SPC_REF_HALF - 1)) begin
            div_d  = 3'h0;
            rclk_d = !rclk_q;
        end
        roe_d = !ctrl_q[`SPC_C_REF_EXT] && ctrl_q[`SPC_C_REF_OUT];
        toe_d = !slave;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {div_q, rclk_q, roe_q, toe_q, aoe_q} <= '0;
        end else begin
            {div_q, rclk_q, roe_q, toe_q, aoe_q} <= {div_d, rclk_d, roe_d, toe_d, aoe_d};
        end
    end

    spc_refmon u_ref (
        .clk     (mclk),
        .rst_n   (rstn),
        .en      (ctrl_q[`SPC_C_REF_EXT]),
        .ref_in  (reference_clock_port_in),
        .missing (refmiss)
    );

    // ----------------------------------------
    // read mux and outputs
    // ----------------------------------------
    always_comb begin
        rmux = `SPC_ZERO;
        if (ch_hit) begin
            rmux = rd_ch[ch_sel][3'((ch_off - `SPC_O_CFG) >> 2)];
        end else begin
            unique case (avs_address)
                `SPC_A_CTRL:  rmux = ctrl_q;
                `SPC_A_RATIO: rmux = ratio_q;
                `SPC_A_DELAY: rmux = dly_q;
                `SPC_A_STATUS: rmux[`SPC_S_PEND:`SPC_S_REFMISS] =
                    {st_q == SS_WAIT, aux_in, ovp[1], ovp[0], refmiss};
                default: rmux = `SPC_ZERO;
            endcase
        end
    end

    assign avs_readdata             = rdata_q;
    assign avs_waitrequest          = wait_q;
    assign aux_oe                   = aoe_q;
    assign reference_clock_port_out = rclk_q;
    assign reference_clock_port_oe  = roe_q;
    assign trig_oe                  = toe_q;
endmodule

// ==== src/spc_cfg.svh ====
// spc_cfg.svh: register map, field positions, codes, resets and timing counts
// assumes a 100 MHz mclk and a byte-addressed 32-bit Avalon-MM slave port
// Behaviour
// - one 100 ns sync pulse per carrier period
// - no sync above 10 MHz carrier
// - no sync for noise or dc
// - arbitrary wave pulses once per repetition
// - internal modulation pulses at modulating rate
// - internal keying pulses at keying rate
// - external modulation turns aux into input
// - sweep or burst disables sync output
// - sync needs enable; source channel selectable
// - internal reference default; external lock; drive out
// - flag missing external reference, keep selection
// - locked mode resets both accumulators together
// - independent mode: no reset on frequency writes, phase writes blocked
// - integer ratio kept exact via control word
// - overvoltage turns output off and alerts
// - trip at 11 V if large setting, else 4 V
// - host sends sync event, slave receives it
// - slave applies configurable delay compensation
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SPC_CLK_MHZ      100
`define SPC_SYNC_NS      100
`define SPC_SYNC_CYC     (`SPC_SYNC_NS * `SPC_CLK_MHZ / 1000)
`define SPC_SYNC_MAX_MHZ 10
`define SPC_FTW_MAX      (64'h0000_0001_0000_0000 * `SPC_SYNC_MAX_MHZ / `SPC_CLK_MHZ)
`define SPC_REF_MHZ      10
`define SPC_REF_HALF     (`SPC_CLK_MHZ / `SPC_REF_MHZ / 2)
`define SPC_REF_TMO_NS   1000
`define SPC_REF_TMO_CYC  (`SPC_REF_TMO_NS * `SPC_CLK_MHZ / 1000)

// ----------------------------------------
// overvoltage levels in mV
// ----------------------------------------
`define SPC_OVP_HI_MV    16'h2AF8
`define SPC_OVP_LO_MV    16'h0FA0
`define SPC_AMP_BIG_MV   16'h0C80
`define SPC_OFS_BIG_MV   16'h07D0

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SPC_A_CTRL       8'h00
`define SPC_A_RATIO      8'h20
`define SPC_A_DELAY      8'h40
`define SPC_A_CMD        8'h44
`define SPC_A_STATUS     8'h48
`define SPC_A_CH_BIT     5
`define SPC_O_CFG        5'h04
`define SPC_O_FTW        5'h08
`define SPC_O_MFTW       5'h0C
`define SPC_O_PHASE      5'h10
`define SPC_O_LEVEL      5'h14

// ----------------------------------------
// fields and codes
// ----------------------------------------
`define SPC_C_SYNC_EN    0
`define SPC_C_SRC        1
`define SPC_C_REF_EXT    2
`define SPC_C_REF_OUT    3
`define SPC_C_LOCKED     4
`define SPC_C_COMP       5
`define SPC_C_SLAVE      6
`define SPC_CTRL_RST     32'h0000_0010
`define SPC_F_WAVE       2:0
`define SPC_F_MOD        7:4
`define SPC_F_MEXT       8
`define SPC_F_SWEEP      9
`define SPC_F_BURST      10
`define SPC_F_OUTEN      11
`define SPC_W_BASIC      3'h0
`define SPC_W_ARB        3'h1
`define SPC_W_NOISE      3'h2
`define SPC_W_DC         3'h3
`define SPC_M_NONE       4'h0
`define SPC_M_LAST       4'h8
`define SPC_F_AMP        15:0
`define SPC_F_OFS        31:16
`define SPC_F_RATIO      7:0
`define SPC_R_DIR        8
`define SPC_F_DELAY      15:0
`define SPC_K_SEND       0
`define SPC_S_REFMISS    0
`define SPC_S_OVP0       1
`define SPC_S_AUX        3
`define SPC_S_PEND       4
`define SPC_ZERO         32'h0000_0000

`endif

// ==== src/spc_pkg.sv ====
// spc_pkg: shared types of the sync, reference and phase control block
// assumes spc_cfg.svh holds every number
package spc_pkg;
    typedef logic [31:0] spc_word_t;
    // slave sync event handling
    typedef enum logic {SS_IDLE, SS_WAIT} spc_slv_st_t;
endpackage

// ==== src/spc_pulse.sv ====
// spc_pulse: fixed-width pulse stretcher for the sync output
// assumes trig and clr are synchronous single-cycle or level terms
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_pulse (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic trig,
    input  wire logic clr,
    // pulse out
    output logic      pulse
);
    logic [3:0] cnt_q, cnt_d;
    logic       pulse_q, pulse_d;

    // ----------------------------------------
    // width counter
    // ----------------------------------------
    // a new wrap restarts the width so pulses never merge shorter
    always_comb begin
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = 4'h0;
        end else if (trig) begin
            cnt_d = 4'(`SPC_SYNC_CYC);
        end else if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
        pulse_d = (cnt_d != 4'h0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 4'h0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
endmodule

// ==== src/spc_refmon.sv ====
// spc_refmon: watches the reference port for a live external clock
// assumes ref_in is already synchronous to clk
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_refmon (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // monitor
    input  wire logic en,
    input  wire logic ref_in,
    output logic      missing
);
    logic       prev_q, prev_d;
    logic [7:0] cnt_q, cnt_d;
    logic       miss_q, miss_d;

    // ----------------------------------------
    // edge timeout
    // ----------------------------------------
    // only a stuck line is caught, not a wrong frequency
    always_comb begin
        prev_d = ref_in;
        cnt_d  = cnt_q;
        miss_d = miss_q;
        if (!en) begin
            cnt_d  = 8'h00;
            miss_d = 1'b0;
        end else if (ref_in && !prev_q) begin
            cnt_d  = 8'h00;
            miss_d = 1'b0;
        end else if (cnt_q == 8'(`SPC_REF_TMO_CYC - 1)) begin
            miss_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            cnt_q  <= 8'h00;
            miss_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q  <= cnt_d;
            miss_q <= miss_d;
        end
    end

    assign missing = miss_q;
endmodule

// ==== sim/spc_assertions.sv ====
// spc_assertions: port-level checks on spc_top
// assumes it is bound to spc_top by the bench top file
`timescale 1ns/100ps
module spc_assertions (
    // clock, reset and bus handshake
    input wire logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest,
    // sync, trigger and reference pins
    input wire logic        aux_out, aux_oe, trig_out, trig_oe, reference_clock_port_out,
    // channel outputs
    input wire logic [15:0] first_channel_vmag_mv, second_channel_vmag_mv,
    input wire logic        first_channel_out_en, second_channel_out_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a waiting request is answered on the next cycle, and only for one cycle
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    // quiet bus for eight cycles means the pulse runs its full width
    sync_width_a: assert property ($rose(aux_out) ##0 avs_waitrequest[*8]
        |-> aux_out[*8] ##1 aux_out[*2] ##1 !aux_out) else $error("sync pulse width");
    sync_off_a: assert property (!aux_oe[*2] |-> !aux_out)
        else $error("sync driven while off");
    trig_pulse_a: assert property ($rose(trig_out) |-> trig_out[*8] ##1 trig_out[*2]
        ##1 !trig_out) else $error("sync event width");
    trig_drive_a: assert property (trig_out |-> trig_oe) else $error("event undriven");
    // above the high level every setting trips
    ovp_first_a: assert property (first_channel_vmag_mv > 16'h2af8 |=> !first_channel_out_en)
        else $error("first output not tripped");
    ovp_second_a: assert property (second_channel_vmag_mv > 16'h2af8 |=> !second_channel_out_en)
        else $error("second output not tripped");
    ref_half_a: assert property ($rose(reference_clock_port_out)
        |-> reference_clock_port_out[*5] ##1 !reference_clock_port_out)
        else $error("reference half period");
    cover property ($rose(aux_out));
    cover property ($fell(first_channel_out_en));
    cover property ($rose(trig_out));
endmodule

// ==== sim/spc_partner.sv ====
// spc_partner: external reference source and sync event sender
// assumes the bench switches the reference and raises ev
`timescale 1ns/100ps
module spc_partner (
    input  wire logic mclk,
    input  wire logic ref_on,
    input  wire logic ev,
    output logic      ref_clk,
    output logic      trig
);
    int n = 0;
    initial begin
        ref_clk = 0;
        trig = 0;
    end
    // 10 MHz source; a dead source freezes its level, as a lost cable does
    always @(posedge mclk) begin
        n <= (n == 4) ? 0 : n + 1;
        if (ref_on && n == 4) ref_clk <= !ref_clk;
        trig <= ev;
    end
endmodule

// ==== sim/tb_sync_pulse_phase_control.sv ====
// tb_sync_pulse_phase_control: self-checking bench of spc_top
// assumes spc_partner and spc_assertions are compiled first
`timescale 1ns/100ps
module tb_sync_pulse_phase_control import spc_pkg::*;;
    logic        mclk = 0, rst_n = 0, rd = 0, wr = 0, ref_on = 0, ev = 0, aop = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdq, q, p1, p2, lf = 32'h0000_9fb8, tb[6];
    logic [15:0] v1 = 16'h0000, v2 = 16'h0000;
    logic        wq, ao, aoe, rc, rco, rcoe, ti, tro, toe, e1, e2;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, last = 0, gapv = 0, nr = 0, n0;
    spc_top dut_u (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdq),
        .avs_waitrequest(wq), .aux_in(1'b0), .aux_out(ao), .aux_oe(aoe),
        .reference_clock_port_in(rc), .reference_clock_port_out(rco),
        .reference_clock_port_oe(rcoe), .trig_in(ti), .trig_out(tro), .trig_oe(toe),
        .first_channel_vmag_mv(v1), .first_channel_phase(p1), .first_channel_out_en(e1),
        .second_channel_vmag_mv(v2), .second_channel_phase(p2), .second_channel_out_en(e2));
    spc_partner far_u (.mclk(mclk), .ref_on(ref_on), .ev(ev), .ref_clk(rc), .trig(ti));
    initial forever #5 mclk = ~mclk;
    // pulse spacing log and run limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        aop <= ao;
        if (ao && !aop) begin
            gapv <= cyc - last;
            last <= cyc;
            nr <= nr + 1;
        end
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    function automatic logic [31:0] per(input logic [31:0] f);
        return 32'((33'h1_0000_0000) / f);
    endfunction
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // one bus cycle: hold until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        while (wq !== 1'b0 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        if (k == 50) n_mismatch++;
        q = rdq;
        wr <= 0;
        rd <= 0;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ov(input logic [31:0] lv, input logic [15:0] v, input logic ex);
        bus(1, 8'h14, lv);
        bus(1, 8'h48, 32'h0000_0002);
        bus(1, 8'h04, 32'h0000_0800);
        v1 <= v;
        repeat (3) @(posedge mclk);
        chk(32'(e1), 32'(ex));
        v1 <= 16'h0000;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tb = '{32'h2, 32'h3, 32'h100, 32'h200, 32'h400, 32'h0};
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        repeat (4) @(posedge mclk);
        bus(0, 8'h00, 0);
        chk(q, 32'h0000_0010);
        bus(0, 8'h80, 0);
        chk(q, 32'h0000_0000);
        bus(1, 8'h00, 32'h0000_0011);
        bus(1, 8'h08, 32'h1000_0000);
        bus(1, 8'h04, 32'h0000_0001);
        repeat (150) @(posedge mclk);
        chk(gapv, per(32'h1000_0000));
        for (int i = 0; i < 6; i++) begin
            if (i == 5) bus(1, 8'h08, 32'h2000_0000);
            bus(1, 8'h04, tb[i]);
            repeat (20) @(posedge mclk);
            n0 = nr;
            repeat (64) @(posedge mclk);
            chk(nr - n0, 0);
        end
        bus(1, 8'h08, 32'h1000_0000);
        for (int m = 1; m < 9; m++) begin
            lf = nx(lf);
            bus(1, 8'h0C, 32'h1 << (27 - lf[0]));
            bus(1, 8'h04, m << 4);
            repeat (150) @(posedge mclk);
            chk(gapv, per(32'h1 << (27 - lf[0])));
        end
        bus(1, 8'h00, 32'h0000_0013);
        bus(1, 8'h24, 0);
        bus(1, 8'h28, 32'h0800_0000);
        repeat (150) @(posedge mclk);
        chk(gapv, 32);
        bus(1, 8'h00, 32'h0000_0014);
        repeat (150) @(posedge mclk);
        chk(32'(aoe), 0);
        bus(0, 8'h48, 0);
        chk(q, 32'h0000_0001);
        bus(0, 8'h00, 0);
        chk(q, 32'h0000_0014);
        ref_on <= 1;
        repeat (50) @(posedge mclk);
        bus(0, 8'h48, 0);
        chk(q, 32'h0000_0000);
        ov(0, 16'h0fa0, 1);
        ov(0, 16'h0fa1, 0);
        ov(32'h0000_0c80, 16'h2af8, 1);
        ov(32'h07d0_0000, 16'h2af9, 0);
        bus(1, 8'h00, 32'h0000_0010);
        bus(1, 8'h28, 32'h1000_0000);
        bus(1, 8'h30, 32'h4000_0000);
        bus(1, 8'h08, 32'h1000_0000);
        repeat (5) @(posedge mclk);
        chk(p2 - p1, 32'h4000_0000);
        bus(1, 8'h00, 32'h0000_0000);
        bus(1, 8'h30, 32'h8000_0000);
        bus(0, 8'h30, 0);
        chk(q, 32'h4000_0000);
        bus(1, 8'h44, 32'h0000_0001);
        repeat (20) @(posedge mclk);
        bus(1, 8'h40, 100);
        bus(1, 8'h00, 32'h0000_0050);
        ev <= 1;
        repeat (3) @(posedge mclk);
        bus(0, 8'h48, 0);
        chk(q[4], 1);
        repeat (120) @(posedge mclk);
        bus(0, 8'h48, 0);
        chk(q[4], 0);
        results();
    end
endmodule
bind spc_top spc_assertions chk_u (.mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
    .aux_out, .aux_oe, .trig_out, .trig_oe, .reference_clock_port_out,
    .first_channel_vmag_mv, .second_channel_vmag_mv,
    .first_channel_out_en, .second_channel_out_en);
